// ### design/rim_event_monitor.sv
// Event flags, enables, event pin driver and supply monitor with an APB register slave
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "rim_params.svh"

// Functional notes
// - Three sources, own flag, own enable
// - Pin asserts only for flagged enabled source
// - Pulse mode drives pin about 200 ms
// - Level mode holds pin until flags read
// - No interrupts while on backup supply
// - Interrupts valid only after recall completes
// - Watchdog enable gates timeout onto pin
// - Alarm enable gates match onto pin
// - Power loss enable gates fail onto pin
// - Square wave overrides; tuning tone overrides it
// - Square wave settings kept nonvolatile
// - Polarity bit picks push-pull high, open-drain low
// - Active high drive only above switch threshold
// - Rate bits choose 1, 512, 4096, 32768 Hz
// - Flags read clears event flags and level pin
// - Flags read ends pulse early
// - Pin priority: tone, square, interrupt, hi-z
// - Power-up flags zero except oscillator flag
// - Supply fall starts store, switches oscillator
// - Backup supply blocks host access, time runs
// - Backup failure flagged, reported next power-up
module rim_event_monitor #(
  parameter int unsigned PULSE_CYC = `RIM_PULSE_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                watchdog_timeout,
  input  wire logic                alarm_match,
  input  wire logic                osc_stopped,
  input  wire logic                recall_done,
  input  wire logic                vcc_above_switch,
  input  wire logic                backup_above_fail,
  input  wire logic                osc_1hz,
  input  wire logic                osc_512hz,
  input  wire logic                osc_4096hz,
  input  wire logic                osc_32768hz,
  input  wire logic [2:0]          nv_square_cfg,
  output logic [2:0]               nv_square_cfg_wr,
  output logic                     nv_square_cfg_we,
  output logic                     store_start,
  output logic                     osc_on_backup,
  output logic                     host_access_block,
  output logic                     event_pin_o,
  output logic                     event_pin_oe_n
);
  import rim_pkg::*;

  // Register map seen from the bus
  //   0x00 flags: sticky event bits, cleared by a read
  //   0x18 control: enables, pin mode, square wave setup
  //   0x20 status: supply state, live pin request, backup fault
  // Upper read data bits always return zero
  // Writes to the flags word only touch the tuning tone bit
  // Refused accesses answer with an error and change nothing
  // Refusal covers unmapped addresses and any time off main supply

  // Bus timing
  //   Setup cycle is decoded, answer registered for the access cycle
  //   No wait states, so back-to-back transfers are fine
  //   Read data is latched from setup; clear happens at access edge
  //   A read therefore returns flags as they stood before the clear

  // Event path timing
  //   Two flops of synchronisation on every source pin
  //   The rising edge detector adds no cycle; it compares with the previous value
  //   Flag and pulse timer load on that edge
  //   Pin flop follows one cycle later
  //   Events shorter than one clock may be missed by design
  //   Sources are expected to be slow compared to this clock

  // Flag behaviour
  //   Source flags are sticky until a successful flags read
  //   A set in the same cycle as the clearing read wins
  //   The host sees that late event on its next read
  //   Oscillator flag simply mirrors its synchronised input
  //   Backup fault flag is copied in only on main supply
  //   So a fault seen on backup shows up after power returns

  // Pin behaviour
  //   Priority: tuning tone, square wave, interrupt, released
  //   Active high mode drives push-pull, only with main supply good
  //   Active low mode only ever pulls low, else released
  //   Released pin relies on the board pull-up for its level
  //   Pulse mode restarts the timer on each enabled event
  //   Level mode follows flag and enable directly
  //   Clearing an enable in level mode drops the pin at once

  // Supply handling
  //   Start in init; main needs recall done and supply good
  //   Supply fall on main moves to backup and asks for a store
  //   Oscillator switch and host block follow the next state
  //   Supply return goes back through init, so recall is rechecked
  //   No events are taken and the pin is released off main

  // Nonvolatile square wave settings
  //   Loaded once, on the first clock after reset
  //   Every accepted control write is echoed to the store port
  //   Only the square wave enable and rate bits are sent
  //   Pin sources are all ignored until the load is done

  // Limitations
  //   Pulse length is a cycle count, so it tracks the clock rate
  //   Square wave taps are resampled, adding a little jitter
  //   At the fastest rate jitter is a fair share of a period
  //   The status word is a local aid, not part of the device map

  // Two-stage synchronisers for all asynchronous inputs
  // Backup good bit resets high so a start-up zero is not a fault
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic [9:0] async_in;
  assign async_in = {watchdog_timeout, alarm_match, osc_stopped, recall_done,
                     vcc_above_switch, backup_above_fail, osc_1hz, osc_512hz,
                     osc_4096hz, osc_32768hz};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 10'h010;
      sync2_q <= 10'h010;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  wire wd_s    = sync2_q[9];
  wire al_s    = sync2_q[8];
  wire osc_s   = sync2_q[7];
  wire rcl_s   = sync2_q[6];
  wire vcc_s   = sync2_q[5];
  wire bak_s   = sync2_q[4];
  wire sq1_s   = sync2_q[3];
  wire sq512_s = sync2_q[2];
  wire sq4k_s  = sync2_q[1];
  wire sq32k_s = sync2_q[0];

  // Edge detection on the synchronised event sources
  logic wd_prev_q;
  logic al_prev_q;
  logic vcc_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_prev_q  <= 1'b0;
      al_prev_q  <= 1'b0;
      vcc_prev_q <= 1'b0;
    end else begin
      wd_prev_q  <= wd_s;
      al_prev_q  <= al_s;
      vcc_prev_q <= vcc_s;
    end
  end

  // Supply state: init until recall done and supply good
  rim_pwr_state_e pwr_q;
  rim_pwr_state_e pwr_d;
  wire vcc_fall = vcc_prev_q && !vcc_s;
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      RIM_PWR_INIT: begin
        if (rcl_s && vcc_s) begin
          pwr_d = RIM_PWR_MAIN;
        end
      end
      RIM_PWR_MAIN: begin
        if (vcc_fall) begin
          pwr_d = RIM_PWR_BACKUP;
        end
      end
      RIM_PWR_BACKUP: begin
        if (vcc_s) begin
          pwr_d = RIM_PWR_INIT;
        end
      end
      default: pwr_d = RIM_PWR_INIT;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pwr_q <= RIM_PWR_INIT;
    else          pwr_q <= pwr_d;
  end
  wire on_main = (pwr_q == RIM_PWR_MAIN);

  // Events only count on main supply after recall
  wire ev_wd = wd_s && !wd_prev_q && on_main;
  wire ev_al = al_s && !al_prev_q && on_main;
  wire ev_pl = on_main && vcc_fall;

  // APB decode; slave answers with no wait state
  wire acc      = psel && penable;
  wire hit_flg  = (paddr == `RIM_ADDR_FLAGS);
  wire hit_ctl  = (paddr == `RIM_ADDR_CTRL);
  wire hit_sts  = (paddr == `RIM_ADDR_STATUS);
  wire mapped   = hit_flg || hit_ctl || hit_sts;
  // Host blocked while on backup; the access errors instead
  wire blocked  = !on_main;
  wire bad      = !mapped || blocked;
  wire rd_flags = acc && !pwrite && hit_flg && !blocked;
  wire wr_ctl   = acc && pwrite && hit_ctl && !blocked;
  wire wr_flg   = acc && pwrite && hit_flg && !blocked;

  // Control register; square wave fields mirror nonvolatile storage
  logic [7:0] ctl_q;
  logic       nv_loaded_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q       <= `RIM_CTRL_RST;
      nv_loaded_q <= 1'b0;
    end else if (!nv_loaded_q) begin
      ctl_q[`RIM_CTL_SQE:`RIM_CTL_SQE] <= nv_square_cfg[2:2];
      ctl_q[`RIM_CTL_RHI:`RIM_CTL_RLO] <= nv_square_cfg[1:0];
      nv_loaded_q <= 1'b1;
    end else if (wr_ctl) begin
      ctl_q <= pwdata[7:0];
    end
  end

  // Write-through to nonvolatile store on control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_square_cfg_wr <= 3'h0;
      nv_square_cfg_we <= 1'b0;
    end else begin
      nv_square_cfg_we <= wr_ctl && nv_loaded_q;
      nv_square_cfg_wr <= {pwdata[`RIM_CTL_SQE], pwdata[`RIM_CTL_RHI], pwdata[`RIM_CTL_RLO]};
    end
  end

  // Flags: set wins over read clear so no event is lost
  logic [7:0] flg_q;
  logic       bak_fail_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flg_q <= `RIM_FLAGS_RST;
    end else begin
      flg_q[`RIM_FLG_WDOG]  <= ev_wd || (flg_q[`RIM_FLG_WDOG] && !rd_flags);
      flg_q[`RIM_FLG_ALARM] <= ev_al || (flg_q[`RIM_FLG_ALARM] && !rd_flags);
      flg_q[`RIM_FLG_PLOSS] <= ev_pl || (flg_q[`RIM_FLG_PLOSS] && !rd_flags);
      flg_q[`RIM_FLG_OSC]   <= osc_s;
      flg_q[`RIM_FLG_BAK]   <= on_main ? bak_fail_q : flg_q[`RIM_FLG_BAK];
      flg_q[`RIM_FLG_TUNE]  <= wr_flg ? pwdata[`RIM_FLG_TUNE] : flg_q[`RIM_FLG_TUNE];
      flg_q[1:0]            <= 2'b00;
    end
  end

  // Backup supply watched in every state; sticky until reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bak_fail_q <= 1'b0;
    end else if (!bak_s) begin
      bak_fail_q <= 1'b1;
    end else if (rd_flags) begin
      bak_fail_q <= 1'b0;
    end
  end

  // Enabled, pending interrupt
  wire [2:0] pend = {flg_q[`RIM_FLG_WDOG]  && ctl_q[`RIM_CTL_WD_EN],
                     flg_q[`RIM_FLG_ALARM] && ctl_q[`RIM_CTL_AL_EN],
                     flg_q[`RIM_FLG_PLOSS] && ctl_q[`RIM_CTL_PL_EN]};
  wire irq_new  = |({ev_wd, ev_al, ev_pl} & {ctl_q[`RIM_CTL_WD_EN], ctl_q[`RIM_CTL_AL_EN],
                    ctl_q[`RIM_CTL_PL_EN]});

  // Pulse timer: restarted per enabled event, cut short by a read
  logic [31:0] pulse_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_q <= 32'h0;
    end else if (irq_new) begin
      pulse_cnt_q <= PULSE_CYC;
    end else if (rd_flags || !on_main) begin
      pulse_cnt_q <= 32'h0;
    end else if (pulse_cnt_q != 32'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 32'h1;
    end
  end

  // Interrupt active: pulse timer in pulse mode, pending flags in level mode
  wire irq_act = on_main && (ctl_q[`RIM_CTL_PULSE] ? (pulse_cnt_q != 32'h0)
                                                   : (|pend));

  // Square wave rate select
  logic sq_wave;
  always_comb begin
    case (ctl_q[`RIM_CTL_RHI:`RIM_CTL_RLO])
      2'b00:   sq_wave = sq1_s;
      2'b01:   sq_wave = sq512_s;
      2'b10:   sq_wave = sq4k_s;
      default: sq_wave = sq32k_s;
    endcase
  end

  // Pin source by priority; nothing is driven off main supply
  rim_pin_sel_e sel;
  always_comb begin
    if (!on_main)                        sel = RIM_SEL_HIZ;
    else if (flg_q[`RIM_FLG_TUNE])       sel = RIM_SEL_TUNE;
    else if (ctl_q[`RIM_CTL_SQE])        sel = RIM_SEL_SQW;
    else if (ctl_q[`RIM_CTL_WD_EN] || ctl_q[`RIM_CTL_AL_EN] || ctl_q[`RIM_CTL_PL_EN])
                                         sel = RIM_SEL_IRQ;
    else                                 sel = RIM_SEL_HIZ;
  end

  // Active level of the selected source before polarity
  logic act;
  always_comb begin
    case (sel)
      RIM_SEL_TUNE: act = sq512_s;
      RIM_SEL_SQW:  act = sq_wave;
      RIM_SEL_IRQ:  act = irq_act;
      default:      act = 1'b0;
    endcase
  end

  // Pin driver: push-pull high, or open-drain pulling low only
  wire pol_hi   = ctl_q[`RIM_CTL_POL];
  wire drv_en   = (sel != RIM_SEL_HIZ) && (pol_hi ? vcc_s : act);
  wire drv_val  = pol_hi ? act : 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pin_o    <= 1'b0;
      event_pin_oe_n <= 1'b1;
    end else begin
      event_pin_o    <= drv_val;
      event_pin_oe_n <= !drv_en;
    end
  end

  // Store request and oscillator switch on supply fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_start       <= 1'b0;
      osc_on_backup     <= 1'b0;
      host_access_block <= 1'b1;
    end else begin
      store_start       <= on_main && vcc_fall;
      osc_on_backup     <= (pwr_d == RIM_PWR_BACKUP);
      host_access_block <= (pwr_d != RIM_PWR_MAIN);
    end
  end

  // APB read mux and response
  wire [7:0] sts = {5'h00, bak_fail_q, irq_act, on_main};
  wire [7:0] rd_mux = hit_flg ? flg_q : hit_ctl ? ctl_q : hit_sts ? sts : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && bad;
      prdata  <= (psel && !penable && !pwrite && !bad) ? {24'h0, rd_mux} : 32'h0;
    end
  end
endmodule
`default_nettype wire

// ### design/rim_params.svh
// Register offsets, field positions, reset values and timing counts of the event logic
`ifndef RIM_PARAMS_SVH
`define RIM_PARAMS_SVH

// Register byte addresses (printed offsets are register indexes)
`define RIM_IDX_FLAGS        4'h0
`define RIM_IDX_CTRL         4'h6
`define RIM_IDX_STATUS       4'h8
`define RIM_ADDR_FLAGS       8'h00
`define RIM_ADDR_CTRL        8'h18
`define RIM_ADDR_STATUS      8'h20

// Flags register fields
`define RIM_FLG_WDOG         7
`define RIM_FLG_ALARM        6
`define RIM_FLG_PLOSS        5
`define RIM_FLG_OSC          4
`define RIM_FLG_BAK          3
`define RIM_FLG_TUNE         2

// Control register fields
`define RIM_CTL_WD_EN        7
`define RIM_CTL_AL_EN        6
`define RIM_CTL_PL_EN        5
`define RIM_CTL_SQE          4
`define RIM_CTL_POL          3
`define RIM_CTL_PULSE        2
`define RIM_CTL_RHI          1
`define RIM_CTL_RLO          0

// Reset values
`define RIM_FLAGS_RST        8'h00
`define RIM_CTRL_RST         8'h08

// Timing: pulse length in ms and clock rate in Hz
`define RIM_PULSE_MS         200
`define RIM_CLK_HZ           20000000
`define RIM_PULSE_CYC        ((`RIM_CLK_HZ / 1000) * `RIM_PULSE_MS)

`endif

// ### design/rim_pkg.sv
// Types shared by the event and power monitor logic
package rim_pkg;
  typedef enum logic [1:0] {
    RIM_SEL_HIZ  = 2'b00,
    RIM_SEL_IRQ  = 2'b01,
    RIM_SEL_SQW  = 2'b10,
    RIM_SEL_TUNE = 2'b11
  } rim_pin_sel_e;

  typedef enum logic [1:0] {
    RIM_PWR_INIT   = 2'b00,
    RIM_PWR_MAIN   = 2'b01,
    RIM_PWR_BACKUP = 2'b10
  } rim_pwr_state_e;
endpackage

// ### tb/rim_host_pin.sv
// Host side of the event pin: resolves the line the host sees
`timescale 1ns/100ps
`default_nettype none
module rim_host_pin (
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output wire logic pin_level
);
  // A released line rests at the pull-up level, never at a stale value
  assign pin_level = pin_oe_n ? 1'b1 : pin_o;
endmodule
`default_nettype wire

// ### tb/rim_event_monitor_monitor.sv
// Port checker for the event and power monitor block
`timescale 1ns/100ps
`default_nettype none
`include "rim_params.svh"
module rim_monitor #(
  parameter int unsigned PULSE_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  nv_square_cfg_wr,
  input wire logic        nv_square_cfg_we,
  input wire logic        store_start,
  input wire logic        osc_on_backup,
  input wire logic        host_access_block,
  input wire logic        event_pin_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answers without wait states, one cycle wide
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood too long");
  refused_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Host access is refused while blocked, settled for a cycle first
  block_err_a: assert property (psel && !penable && host_access_block
    && $past(host_access_block) |=> pslverr)
    else $error("blocked access not refused");
  nv_write_a: assert property (pready && !pslverr && pwrite && paddr == `RIM_ADDR_CTRL
    |=> nv_square_cfg_we && nv_square_cfg_wr == {$past(pwdata[4]), $past(pwdata[1:0])})
    else $error("square settings not stored");
  store_once_a: assert property (store_start |=> !store_start)
    else $error("store start not a single pulse");
  store_backup_a: assert property ($rose(store_start) |-> ##[0:4] osc_on_backup)
    else $error("oscillator not moved to backup");
  backup_block_a: assert property (osc_on_backup |-> host_access_block)
    else $error("host access open on backup");
  // Pin must stay released while off main supply
  backup_quiet_a: assert property (host_access_block && $past(host_access_block)
    |-> event_pin_oe_n)
    else $error("event pin driven off main supply");
  cover property (store_start);
  cover property (pready && pslverr);
  cover property (nv_square_cfg_we);
endmodule
bind rim_event_monitor rim_monitor #(.PULSE_CYC(PULSE_CYC)) u_rim_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nv_square_cfg_wr(nv_square_cfg_wr), .nv_square_cfg_we(nv_square_cfg_we),
  .store_start(store_start), .osc_on_backup(osc_on_backup),
  .host_access_block(host_access_block), .event_pin_oe_n(event_pin_oe_n));
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the event and power monitor block
`timescale 1ns/100ps
`default_nettype none
`include "rim_params.svh"
module tb_top;
  localparam int unsigned PULSE = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        watchdog_timeout, alarm_match, recall_done, vcc_above_switch, backup_above_fail;
  logic [4:0]  osc_cnt;
  logic [2:0]  nv_square_cfg_wr;
  logic        nv_square_cfg_we, store_start, osc_on_backup, host_access_block;
  logic        event_pin_o, event_pin_oe_n;
  wire         pin_level;
  int          n_errors, n_compared, n_store;

  rim_event_monitor #(.PULSE_CYC(PULSE)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_timeout(watchdog_timeout), .alarm_match(alarm_match), .osc_stopped(1'b0),
    .recall_done(recall_done), .vcc_above_switch(vcc_above_switch),
    .backup_above_fail(backup_above_fail), .osc_1hz(osc_cnt[4]), .osc_512hz(osc_cnt[3]),
    .osc_4096hz(osc_cnt[2]), .osc_32768hz(osc_cnt[1]), .nv_square_cfg(3'h0),
    .nv_square_cfg_wr(nv_square_cfg_wr), .nv_square_cfg_we(nv_square_cfg_we),
    .store_start(store_start), .osc_on_backup(osc_on_backup),
    .host_access_block(host_access_block), .event_pin_o(event_pin_o),
    .event_pin_oe_n(event_pin_oe_n));
  rim_host_pin u_host (.pin_o(event_pin_o), .pin_oe_n(event_pin_oe_n), .pin_level(pin_level));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Scaled oscillator taps: periods of 32, 16, 8 and 4 cycles
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 5'h1;
    if (store_start === 1'b1) n_store++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic fire(input logic wd);
    watchdog_timeout <= wd;
    alarm_match <= !wd;
    repeat (3) @(posedge pclk);
    watchdog_timeout <= 1'b0;
    alarm_match <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_lvl(input logic e, input int lim, input string nm);
    int n = 0;
    while (pin_level !== e && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, {31'h0, e}, {31'h0, pin_level});
  endtask
  task automatic hold_lvl(input logic e, input int n, input string nm);
    repeat (n) begin
      @(posedge pclk);
      chk(nm, {31'h0, e}, {31'h0, pin_level});
    end
  endtask
  // Counts pin edges over 64 cycles; one edge of slack for the synchroniser
  task automatic tog(input int e, input string nm);
    int t = 0;
    logic p;
    repeat (4) @(posedge pclk);
    p = pin_level;
    repeat (64) begin
      @(posedge pclk);
      if (pin_level !== p) t++;
      p = pin_level;
    end
    chk(nm, e, (t >= e - 1 && t <= e + 1) ? e : t);
  endtask

  task automatic t_reset();
    rd(`RIM_ADDR_FLAGS, 32'h0, "flags reset");
    rd(`RIM_ADDR_CTRL, 32'h8, "control reset");
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped refused", 32'h1, {31'h0, err});
  endtask
  task automatic t_level();
    apb(1'b1, `RIM_ADDR_CTRL, 32'h88);
    hold_lvl(1'b0, 4, "idle low");
    fire(1'b1);
    wait_lvl(1'b1, 10, "watchdog drives pin");
    hold_lvl(1'b1, PULSE + 10, "level held");
    fire(1'b0);
    rd(`RIM_ADDR_FLAGS, 32'hc0, "both flags");
    wait_lvl(1'b0, 3, "level cleared by read");
    fire(1'b0);
    hold_lvl(1'b0, 10, "masked alarm quiet");
    rd(`RIM_ADDR_FLAGS, 32'h40, "alarm flag only");
  endtask
  task automatic t_pulse();
    apb(1'b1, `RIM_ADDR_CTRL, 32'h44);
    wait_lvl(1'b1, 3, "released idle");
    chk("open drain idle", 32'h1, {31'h0, event_pin_oe_n});
    fire(1'b0);
    hold_lvl(1'b0, PULSE - 10, "pulse active low");
    wait_lvl(1'b1, 15, "pulse ends");
    rd(`RIM_ADDR_FLAGS, 32'h40, "pulse flag");
    fire(1'b0);
    wait_lvl(1'b0, 2, "second pulse");
    rd(`RIM_ADDR_FLAGS, 32'h40, "second flag");
    wait_lvl(1'b1, 2, "read cuts pulse");
  endtask
  task automatic t_sqw();
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `RIM_ADDR_CTRL, 32'h98 | r);
      tog(4 << r, "square rate");
    end
    apb(1'b1, `RIM_ADDR_FLAGS, 32'h04);
    tog(8, "tuning tone wins");
    apb(1'b1, `RIM_ADDR_FLAGS, 32'h0);
  endtask
  task automatic t_power();
    apb(1'b1, `RIM_ADDR_CTRL, 32'h28);
    vcc_above_switch <= 1'b0;
    backup_above_fail <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("oscillator on backup", 32'h1, {31'h0, osc_on_backup});
    chk("store pulses", 32'h1, n_store);
    chk("pin released on backup", 32'h1, {31'h0, event_pin_oe_n});
    apb(1'b0, `RIM_ADDR_FLAGS, 32'h0);
    chk("backup access refused", 32'h1, {31'h0, err});
    backup_above_fail <= 1'b1;
    vcc_above_switch <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(`RIM_ADDR_FLAGS, 32'h28, "power and backup flags");
  endtask

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {watchdog_timeout, alarm_match, osc_cnt} = '0;
    {recall_done, vcc_above_switch, backup_above_fail} = 3'h7;
    {n_errors, n_compared, n_store} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Pin and registers are ignored until the block reports main supply
    for (int i = 0; i < 20 && host_access_block !== 1'b0; i++) @(posedge pclk);
    t_reset();
    t_level();
    t_pulse();
    t_sqw();
    t_power();
    summarize();
  end
  // Whole run needs about 500 cycles
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
